// *** verilog/lpm_device.sv ***
// device end: instruction decoder, power save control and contrast step register
`timescale 1ns/10ps
`default_nettype none
// Operation
// - 0x22/0x23 switches drive waveform off/on
// - power save needs display off and whole-on
// - power save stops oscillator and supply
// - power save holds outputs and bias high
// - power save keeps mode settings, except drive, which normal display clears on leaving it
// - power save begins on the second instruction
// - normal display instruction leaves power save
// - host may send display on afterward
// - outputs stay high until drive is on
// - 0xA0/0xA1 selects segment order
// - booster 2 to 6 times, needs oscillator
// - contrast code N gives (N+45)/300 reference
// - host keeps test straps not both high
// - host prefers contrast codes above 0x4F
// - strap high parallel, low serial
// - serial mode has no read path
// - serial uses bit 7 data, bit 6 clock
// - reset instruction loads contrast all ones
// - contrast load only in sub table
// - serial msb first, select at eighth edge
module lpm_device
   import lpm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   lpm_link_if.dev         link,
   input  wire logic       testStrapA,
   input  wire logic       testStrapB,
   output logic            powerSave,
   output logic            oscRun,
   output logic            supplyOn,
   output logic            boosterRun,
   output logic [2:0]      boostSel,
   output logic            driveEnable,
   output logic            outputsAtSupply,
   output logic            biasAtSupply,
   output logic            segReverse,
   output logic [7:0]      contrastStep,
   output logic [8:0]      refNumerator,
   output logic            contrastValid,
   output logic            instrStrobe,
   output logic [7:0]      instrByte,
   output logic            dataStrobe,
   output logic [7:0]      dataByte
);
   // three-stage samplers for host control pins; the parallel data bus gets two stages
   logic [2:0] csS_q;
   logic [2:0] selS_q;
   logic [2:0] psS_q;
   logic [2:0] wrS_q;
   logic [2:0] sclS_q;
   logic [2:0] siS_q;
   logic [7:0] busS1_q;
   logic [7:0] busS2_q;
   logic       csN_q;
   logic       sel_q;
   logic       parMode_q;
   logic       wrN_q;
   logic       scl_q;
   logic       si_q;
   logic [7:0] shift_q;
   logic [2:0] bitCnt_q;
   logic       dispOn_q;
   logic       wholeOn_q;
   logic       drive_q;
   logic       segRev_q;
   logic       pwrOn_q;
   logic [2:0] boost_q;
   logic       subMode_q;
   logic [7:0] contrast_q;
   logic       strobe_q;
   logic       strobeSel_q;
   logic [7:0] strobeByte_q;
   logic       wrRise;
   logic       sclRise;
   logic       parStrobe;
   logic       serStrobe;
   logic       anyStrobe;
   logic [7:0] rxByte;
   logic       rxSel;
   logic       isInstr;

   function automatic logic opMatch(input logic [7:0] b, input logic [7:0] op,
                                    input logic [7:0] careMask);
      opMatch = ((b ^ op) & careMask) == 8'h00;
   endfunction

   function automatic logic stable(input logic [2:0] s, input logic held);
      stable = (s[2] == s[1]) ? s[1] : held;
   endfunction

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         csS_q <= 3'h7;  selS_q <= 3'h0; psS_q <= 3'h7;
         // shift clock idles high on the pulled-up bus, so no false edge after reset
         wrS_q <= 3'h7;  sclS_q <= 3'h7; siS_q <= 3'h0;
         busS1_q <= 8'h00; busS2_q <= 8'h00;
         csN_q <= 1'b1; sel_q <= 1'b0; parMode_q <= 1'b1;
         wrN_q <= 1'b1; scl_q <= 1'b1; si_q <= 1'b0;
      end else begin
         csS_q  <= {csS_q[1:0], link.csN};
         selS_q <= {selS_q[1:0], link.cmdDataSel};
         psS_q  <= {psS_q[1:0], link.parSerStrap};
         wrS_q  <= {wrS_q[1:0], link.wrN};
         sclS_q <= {sclS_q[1:0], link.dataBus[6]};
         siS_q  <= {siS_q[1:0], link.dataBus[7]};
         busS1_q <= link.dataBus;
         busS2_q <= busS1_q;
         csN_q <= stable(csS_q, csN_q);
         sel_q <= stable(selS_q, sel_q);
         parMode_q <= stable(psS_q, parMode_q);
         wrN_q <= stable(wrS_q, wrN_q);
         scl_q <= stable(sclS_q, scl_q);
         si_q  <= stable(siS_q, si_q);
      end
   end

   assign wrRise    = ~wrN_q && stable(wrS_q, wrN_q);
   assign sclRise   = ~scl_q && stable(sclS_q, scl_q);
   assign parStrobe = parMode_q && ~csN_q && wrRise;
   assign serStrobe = ~parMode_q && ~csN_q && sclRise && (bitCnt_q == LPM_BIT_LAST);
   assign anyStrobe = parStrobe || serStrobe;
   assign rxByte    = parMode_q ? busS2_q : {shift_q[6:0], si_q};
   assign rxSel     = sel_q; // sampled at the eighth edge in serial mode
   assign isInstr   = strobe_q && ~strobeSel_q;

   // serial shifter clears whenever deselected or in parallel mode
   always_ff @(posedge clk) begin
      if (sys_rst || csN_q || parMode_q) begin
         shift_q  <= 8'h00;
         bitCnt_q <= 3'h0;
      end else if (sclRise) begin
         shift_q  <= {shift_q[6:0], si_q};
         bitCnt_q <= bitCnt_q + 3'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         strobe_q <= 1'b0; strobeSel_q <= 1'b0; strobeByte_q <= 8'h00;
      end else begin
         strobe_q <= anyStrobe;
         if (anyStrobe) begin
            strobeSel_q  <= rxSel;
            strobeByte_q <= rxByte;
         end
      end
   end

   // instruction decode; settings only change by instruction, and normal display clears drive when leaving power save
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         dispOn_q <= 1'b0; wholeOn_q <= 1'b0; drive_q <= 1'b0; segRev_q <= 1'b0;
         pwrOn_q <= 1'b0; boost_q <= LPM_BOOST_RST; subMode_q <= 1'b0;
         contrast_q <= LPM_CONTRAST_RST;
      end else if (isInstr) begin
         if (subMode_q) begin
            if (strobeByte_q == LPM_OP_SUB_EXIT) begin
               subMode_q <= 1'b0;
            end else begin
               contrast_q <= strobeByte_q;
            end
         end else if (opMatch(strobeByte_q, LPM_OP_DRIVE, 8'hFE)) begin
            drive_q <= strobeByte_q[0];
         end else if (opMatch(strobeByte_q, LPM_OP_DISP, 8'hFE)) begin
            dispOn_q <= strobeByte_q[0];
         end else if (opMatch(strobeByte_q, LPM_OP_WHOLE, 8'hFE)) begin
            wholeOn_q <= strobeByte_q[0];
            if (!strobeByte_q[0] && powerSave) begin
               drive_q <= 1'b0;
            end
         end else if (opMatch(strobeByte_q, LPM_OP_SEGORDER, 8'hFE)) begin
            segRev_q <= strobeByte_q[0];
         end else if (opMatch(strobeByte_q, LPM_OP_PWR, 8'hFE)) begin
            pwrOn_q <= strobeByte_q[0];
         end else if (opMatch(strobeByte_q, LPM_OP_BOOST, 8'hF8)) begin
            boost_q <= strobeByte_q[2] ? LPM_BOOST_RST : strobeByte_q[2:0];
         end else if (strobeByte_q == LPM_OP_SUB_ENTER) begin
            subMode_q <= 1'b1;
         end else if (strobeByte_q == LPM_OP_RESET) begin
            contrast_q <= LPM_CONTRAST_RST;
            boost_q    <= LPM_BOOST_RST;
         end
      end
   end

   // both stored bits must hold, so the second instruction starts it
   assign powerSave       = ~dispOn_q && wholeOn_q;
   assign oscRun          = ~powerSave;
   assign supplyOn        = pwrOn_q && ~powerSave;
   assign boosterRun      = supplyOn && oscRun;
   assign boostSel        = boost_q;
   assign driveEnable     = drive_q && ~powerSave;
   assign outputsAtSupply = ~driveEnable;
   assign biasAtSupply    = powerSave;
   assign segReverse      = segRev_q;
   assign contrastStep    = contrast_q;
   assign refNumerator    = {1'b0, contrast_q} + LPM_REF_OFFSET;
   // contrast adjustment invalid with both test straps high or supply off
   assign contrastValid   = supplyOn && ~(testStrapA && testStrapB);
   assign instrStrobe     = isInstr;
   assign instrByte       = strobeByte_q;
   assign dataStrobe      = strobe_q && strobeSel_q;
   assign dataByte        = strobeByte_q;

   // only writes are supported here; the bus is never driven, and never in serial mode
   assign link.dataDev   = 8'h00;
   assign link.dataDevOe = 8'h00;
endmodule : lpm_device
`default_nettype wire

// *** verilog/lpm_pkg.sv ***
// package of constants and types shared by both ends of the instruction link
package lpm_pkg;
   localparam logic [7:0] LPM_OP_DRIVE     = 8'h22; // 0010001x
   localparam logic [7:0] LPM_OP_DISP      = 8'hAE; // 1010111x
   localparam logic [7:0] LPM_OP_WHOLE     = 8'hA4; // 1010010x
   localparam logic [7:0] LPM_OP_SEGORDER  = 8'hA0; // 1010000x
   localparam logic [7:0] LPM_OP_PWR       = 8'h28; // 0010100x
   localparam logic [7:0] LPM_OP_BOOST     = 8'h64; // 01100xxx
   localparam logic [7:0] LPM_OP_SUB_ENTER = 8'h70;
   localparam logic [7:0] LPM_OP_SUB_EXIT  = 8'h71;
   localparam logic [7:0] LPM_OP_RESET     = 8'hE2;
   localparam logic [7:0] LPM_CONTRAST_RST = 8'hFF;
   localparam logic [2:0] LPM_BOOST_RST    = 3'h4;
   localparam logic [8:0] LPM_REF_OFFSET   = 9'h02D; // 45 of 300
   localparam logic [8:0] LPM_REF_FULL     = 9'h12C; // 300
   localparam logic [2:0] LPM_BIT_LAST     = 3'h7;
   localparam logic [3:0] LPM_SCL_DIV      = 4'h7;
   typedef enum logic [1:0] {
      LPM_HS_IDLE = 2'b00,
      LPM_HS_SHIFT = 2'b01,
      LPM_HS_STROBE = 2'b10
   } lpm_hs_t;
endpackage : lpm_pkg

// *** verilog/lpm_link_if.sv ***
// interface joining the host end and the device end
`timescale 1ns/10ps
`default_nettype none
interface lpm_link_if;
   logic       csN;
   logic       cmdDataSel;
   logic       parSerStrap;
   logic       busStyleStrap;
   logic       rdN;
   logic       wrN;
   logic [7:0] dataHost;
   logic [7:0] dataHostOe;
   logic [7:0] dataDev;
   logic [7:0] dataDevOe;
   logic [7:0] dataBus;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         dataBus[i] = dataHostOe[i] ? dataHost[i] : (dataDevOe[i] ? dataDev[i] : 1'b1);
      end
   end
   modport host (output csN, output cmdDataSel, output parSerStrap, output busStyleStrap,
                 output rdN, output wrN, output dataHost, output dataHostOe, input dataBus);
   modport dev  (input csN, input cmdDataSel, input parSerStrap, input busStyleStrap,
                 input rdN, input wrN, output dataDev, output dataDevOe, input dataBus);
endinterface : lpm_link_if
`default_nettype wire

// *** verilog/lpm_host.sv ***
// host end: issues instruction bytes over the parallel or serial port
`timescale 1ns/10ps
`default_nettype none
module lpm_host
   import lpm_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       sys_rst,
   lpm_link_if.host        link,
   input  wire logic       serialMode,
   input  wire logic       cmdValid,
   input  wire logic       cmdIsData,
   input  wire logic [7:0] cmdByte,
   output logic            cmdReady
);
   lpm_hs_t    state_q;
   logic [7:0] shift_q;
   logic [2:0] bitCnt_q;
   logic [3:0] div_q;
   logic       phase_q;
   logic       isData_q;
   logic       sclTick;

   assign sclTick  = (div_q == LPM_SCL_DIV);
   assign cmdReady = (state_q == LPM_HS_IDLE);

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         state_q  <= LPM_HS_IDLE;
         shift_q  <= 8'h00;
         bitCnt_q <= 3'h0;
         div_q    <= 4'h0;
         phase_q  <= 1'b0;
         isData_q <= 1'b0;
      end else begin
         // divider held in idle so the first half period after a take is full length
         div_q <= (sclTick || (state_q == LPM_HS_IDLE)) ? 4'h0 : div_q + 4'h1;
         case (state_q)
            LPM_HS_IDLE: begin
               if (cmdValid) begin
                  shift_q  <= cmdByte;
                  isData_q <= cmdIsData;
                  bitCnt_q <= 3'h0;
                  phase_q  <= 1'b0;
                  state_q  <= serialMode ? LPM_HS_SHIFT : LPM_HS_STROBE;
               end
            end
            LPM_HS_SHIFT: begin
               if (sclTick) begin
                  phase_q <= ~phase_q;
                  if (phase_q) begin
                     // msb first, one bit per rising shift clock
                     shift_q  <= {shift_q[6:0], 1'b0};
                     bitCnt_q <= bitCnt_q + 3'h1;
                     if (bitCnt_q == LPM_BIT_LAST) begin
                        state_q <= LPM_HS_IDLE;
                     end
                  end
               end
            end
            LPM_HS_STROBE: begin
               if (sclTick) begin
                  phase_q <= 1'b1;
                  if (phase_q) begin
                     state_q <= LPM_HS_IDLE;
                  end
               end
            end
            default: state_q <= LPM_HS_IDLE;
         endcase
      end
   end

   // strap and select levels driven toward the device
   assign link.parSerStrap   = ~serialMode;
   assign link.busStyleStrap = 1'b0;
   assign link.csN           = (state_q == LPM_HS_IDLE);
   assign link.cmdDataSel    = isData_q;
   assign link.rdN           = 1'b1;
   // strobe low first; data and select then held a half period past its rising edge,
   // because the device sees the edge only after its pin samplers
   assign link.wrN           = ~((state_q == LPM_HS_STROBE) && !phase_q);
   always_comb begin
      link.dataHost   = 8'h00;
      link.dataHostOe = 8'h00;
      if (state_q == LPM_HS_STROBE) begin
         link.dataHost   = shift_q;
         link.dataHostOe = 8'hFF;
      end else if (state_q == LPM_HS_SHIFT) begin
         // bit 7 carries data, bit 6 the shift clock
         link.dataHost   = {shift_q[7], phase_q, 6'h00};
         link.dataHostOe = 8'hC0;
      end
   end
endmodule : lpm_host
`default_nettype wire

// *** sim/lpm_link_assertions.sv ***
// checker of power save, contrast and port rules seen beside the link
`timescale 1ns/10ps
`default_nettype none
module lpm_link_assertions
   import lpm_pkg::*;
(
   input wire logic       clk,
   input wire logic       sys_rst,
   input wire logic       parSerStrap,
   input wire logic [7:0] dataHostOe,
   input wire logic [7:0] dataDevOe,
   input wire logic       powerSave,
   input wire logic       oscRun,
   input wire logic       supplyOn,
   input wire logic       boosterRun,
   input wire logic       driveEnable,
   input wire logic       outputsAtSupply,
   input wire logic       biasAtSupply,
   input wire logic [7:0] contrastStep,
   input wire logic [8:0] refNumerator,
   input wire logic       instrStrobe,
   input wire logic [7:0] instrByte
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   // main-table use only: in the sub table this byte loads the contrast step
   sequence s_normalTaken;
      instrStrobe && instrByte == LPM_OP_WHOLE;
   endsequence
   property p_saveExit;
      s_normalTaken |-> ##[1:3] !powerSave;
   endproperty
   property p_saveEntry;
      $rose(powerSave) |-> $past(instrByte) == (LPM_OP_WHOLE | 8'h01);
   endproperty
   property p_saveStops;
      powerSave |-> !oscRun && !supplyOn;
   endproperty
   property p_saveHigh;
      powerSave |-> outputsAtSupply && biasAtSupply;
   endproperty
   // leaving power save must not restart the drive by itself
   property p_idleHigh;
      s_normalTaken ##0 powerSave |=> outputsAtSupply && !driveEnable;
   endproperty
   property p_boostOsc;
      boosterRun |-> oscRun;
   endproperty
   property p_refLevel;
      refNumerator == {1'b0, contrastStep} + LPM_REF_OFFSET;
   endproperty
   property p_noRead;
      !parSerStrap |-> dataDevOe == 8'h00;
   endproperty
   property p_serPins;
      !parSerStrap |-> dataHostOe[5:0] == 6'h00;
   endproperty
   a_saveExit: assert property (p_saveExit)
      else $error("power save kept after normal display");
   a_saveEntry: assert property (p_saveEntry)
      else $error("power save began without whole display on");
   a_saveStops: assert property (p_saveStops)
      else $error("oscillator or supply running in power save");
   a_saveHigh: assert property (p_saveHigh)
      else $error("outputs or bias not at supply in power save");
   a_idleHigh: assert property (p_idleHigh)
      else $error("outputs left supply level while drive off");
   a_boostOsc: assert property (p_boostOsc)
      else $error("booster running without oscillator");
   a_refLevel: assert property (p_refLevel)
      else $error("reference numerator not code plus offset");
   a_noRead: assert property (p_noRead)
      else $error("device drives data in serial mode");
   a_serPins: assert property (p_serPins)
      else $error("low data bits driven in serial mode");
endmodule // lpm_link_assertions
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking bench for host and device joined through the link
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin mismatches++; \
   $display("unexpected at %0t: %h not %h", $time, (a), (b)); end end
module tb_top
   import lpm_pkg::*;
;
   logic       clk;
   logic       sys_rst;
   logic       serialMode;
   logic       cmdValid;
   logic       cmdIsData;
   logic [7:0] cmdByte;
   logic       cmdReady;
   logic       powerSave, oscRun, supplyOn, boosterRun, driveEnable;
   logic       outputsAtSupply, biasAtSupply, segReverse, contrastValid;
   logic       instrStrobe, dataStrobe;
   logic [2:0] boostSel;
   logic [7:0] contrastStep, instrByte, dataByte, shiftReg, wireByte;
   logic [8:0] refNumerator;
   logic       wireSel;
   logic       testStrapA;
   logic       testStrapB;
   int         checked = 0;
   int         mismatches = 0;
   int         bitCnt = 0;
   lpm_link_if link ();
   lpm_host i_lpm_host (.clk(clk), .sys_rst(sys_rst), .link(link), .serialMode(serialMode),
      .cmdValid(cmdValid), .cmdIsData(cmdIsData), .cmdByte(cmdByte), .cmdReady(cmdReady));
   // straps kept apart so contrast adjustment stays usable
   lpm_device i_lpm_device (.clk(clk), .sys_rst(sys_rst), .link(link),
      .testStrapA(testStrapA), .testStrapB(testStrapB), .powerSave(powerSave),
      .oscRun(oscRun), .supplyOn(supplyOn),
      .boosterRun(boosterRun), .boostSel(boostSel), .driveEnable(driveEnable),
      .outputsAtSupply(outputsAtSupply), .biasAtSupply(biasAtSupply), .segReverse(segReverse),
      .contrastStep(contrastStep), .refNumerator(refNumerator), .contrastValid(contrastValid),
      .instrStrobe(instrStrobe), .instrByte(instrByte), .dataStrobe(dataStrobe),
      .dataByte(dataByte));
   lpm_link_assertions i_lpm_link_assertions (.clk(clk), .sys_rst(sys_rst),
      .parSerStrap(link.parSerStrap), .dataHostOe(link.dataHostOe), .dataDevOe(link.dataDevOe),
      .powerSave(powerSave), .oscRun(oscRun), .supplyOn(supplyOn), .boosterRun(boosterRun),
      .driveEnable(driveEnable), .outputsAtSupply(outputsAtSupply),
      .biasAtSupply(biasAtSupply), .contrastStep(contrastStep), .refNumerator(refNumerator),
      .instrStrobe(instrStrobe), .instrByte(instrByte));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // wire monitors rebuild each byte from the pins, not from the host's intent
   always @(posedge link.wrN) if (!link.csN && link.parSerStrap) begin
      wireByte = link.dataBus;
      wireSel = link.cmdDataSel;
   end
   always @(posedge link.dataBus[6]) if (!link.csN && !link.parSerStrap) begin
      shiftReg = {shiftReg[6:0], link.dataBus[7]};
      bitCnt++;
      if (bitCnt == 8) begin
         wireByte = shiftReg;
         wireSel = link.cmdDataSel;
         bitCnt = 0;
      end
   end
   // any chip select change ends a partial serial unit
   always @(link.csN) bitCnt = 0;
   task automatic give_verdict();
      $display("checked %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic send(input logic isData, input logic [7:0] val);
      int n = 0;
      while (cmdReady !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      if (n >= 400) mismatches++;
      cmdValid = 1'b1;
      cmdIsData = isData;
      cmdByte = val;
      @(negedge clk);
      cmdValid = 1'b0;
      n = 0;
      // settings land one edge after the strobe, so step past it before checking
      while (instrStrobe !== 1'b1 && dataStrobe !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      if (n >= 400) mismatches++;
      `CHK({wireSel, wireByte}, {isData, val})
      `CHK(isData ? dataByte : instrByte, val)
      @(negedge clk);
   endtask
   task automatic suite();
      send(1'b0, 8'h23);
      `CHK({driveEnable, outputsAtSupply}, 2'b10)
      send(1'b0, 8'h22);
      `CHK({driveEnable, outputsAtSupply}, 2'b01)
      send(1'b0, 8'hA1);
      `CHK(segReverse, 1'b1)
      send(1'b0, 8'hA0);
      `CHK(segReverse, 1'b0)
      for (int c = 0; c < 8; c++) begin
         send(1'b0, LPM_OP_BOOST - 8'h04 + c[7:0]);
         `CHK(boostSel, c[2] ? 3'h4 : c[2:0])
      end
      `CHK(contrastValid, 1'b0)
      send(1'b0, 8'h29);
      `CHK({supplyOn, boosterRun}, 2'b11)
      testStrapA = 1'b1;
      @(negedge clk);
      `CHK(contrastValid, 1'b1)
      testStrapA = 1'b0;
      send(1'b0, 8'h80);
      `CHK(contrastStep, LPM_CONTRAST_RST)
      send(1'b0, LPM_OP_SUB_ENTER);
      send(1'b0, 8'h50);
      `CHK(contrastStep, 8'h50)
      `CHK(refNumerator, 9'h07D)
      send(1'b0, LPM_OP_SUB_EXIT);
      send(1'b0, 8'h37);
      `CHK(contrastStep, 8'h50)
      send(1'b0, 8'hA1);
      send(1'b0, 8'h23);
      send(1'b0, 8'hAF);
      send(1'b0, 8'hA5);
      `CHK(powerSave, 1'b0)
      send(1'b0, 8'hA4);
      send(1'b0, 8'hAE);
      `CHK(powerSave, 1'b0)
      send(1'b0, 8'hA5);
      `CHK({powerSave, oscRun, supplyOn}, 3'b100)
      `CHK({outputsAtSupply, biasAtSupply}, 2'b11)
      `CHK({segReverse, contrastStep, boostSel}, {1'b1, 8'h50, 3'h4})
      send(1'b0, 8'hA4);
      `CHK({powerSave, oscRun, supplyOn, outputsAtSupply}, 4'b0111)
      send(1'b0, 8'hAF);
      `CHK(outputsAtSupply, 1'b1)
      send(1'b0, 8'h23);
      `CHK(outputsAtSupply, 1'b0)
      send(1'b1, 8'h5A);
      send(1'b0, LPM_OP_RESET);
      `CHK({contrastStep, boostSel}, {LPM_CONTRAST_RST, LPM_BOOST_RST})
   endtask
   initial begin
      sys_rst = 1'b1;
      serialMode = 1'b0;
      cmdValid = 1'b0;
      cmdIsData = 1'b0;
      cmdByte = 8'h00;
      testStrapA = 1'b0;
      testStrapB = 1'b0;
      for (int m = 0; m < 2; m++) begin
         @(negedge clk);
         serialMode = m[0];
         sys_rst = 1'b1;
         repeat (3) @(negedge clk);
         sys_rst = 1'b0;
         repeat (4) @(negedge clk);
         `CHK({powerSave, oscRun, driveEnable, outputsAtSupply}, 4'b0101)
         `CHK({contrastStep, boostSel}, {LPM_CONTRAST_RST, LPM_BOOST_RST})
         suite();
      end
      give_verdict();
   end
   initial begin
      #160000;
      mismatches++;
      give_verdict();
   end
endmodule // tb_top
`default_nettype wire
